// file: boundary_cell.sv
`timescale 1ns/10ps
`include "scan_consts.svh"

module boundary_cell
  import scan_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Controller side
  input  wire logic tck_rise,
  input  wire logic tck_fall,
  input  wire logic capture,
  input  wire logic shift_n,
  input  wire logic update,
  input  wire logic treset,
  input  wire logic mode,
  input  wire logic scan_in,
  output logic      scan_out,
  // Pad and logic array side
  input  wire logic pad_in,
  input  wire logic func_out,
  input  wire logic pad_tristate_sig,
  output logic      pad_out,
  output logic      pad_oe_n
);

  logic dir_sh_r;
  logic data_sh_r;
  logic dir_upd_r;
  logic data_upd_r;
  logic dir_upd_nxt;
  logic data_upd_nxt;
  logic output_direction_flag;
  logic pad_out_r;
  logic pad_oe_n_r;

  // Test mode hands the buffer to the update latches
  assign output_direction_flag = mode ? dir_upd_r : pad_tristate_sig;

  // ****************************************
  // Shift stages: direction cell feeds data cell
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dir_sh_r  <= 1'b0;
      data_sh_r <= 1'b0;
    end
    else if (tck_rise && capture)
    begin
      dir_sh_r  <= output_direction_flag;
      data_sh_r <= output_direction_flag ? func_out : pad_in;
    end
    else if (tck_rise && !shift_n)
    begin
      dir_sh_r  <= scan_in;
      data_sh_r <= dir_sh_r;
    end
  end

  assign scan_out = data_sh_r;

  // ****************************************
  // Update latches, loaded on the falling TCK
  // ****************************************
  always_comb
  begin
    dir_upd_nxt  = dir_upd_r;
    data_upd_nxt = data_upd_r;
    if (treset)
    begin
      dir_upd_nxt  = 1'b0;
      data_upd_nxt = 1'b0;
    end
    else if (tck_fall && update)
    begin
      dir_upd_nxt  = dir_sh_r;
      data_upd_nxt = data_sh_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dir_upd_r  <= 1'b0;
      data_upd_r <= 1'b0;
    end
    else
    begin
      dir_upd_r  <= dir_upd_nxt;
      data_upd_r <= data_upd_nxt;
    end
  end

  // Pads take the new latch value in the same cycle as the fall
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pad_out_r  <= 1'b0;
      pad_oe_n_r <= 1'b1;
    end
    else
    begin
      pad_out_r  <= mode ? data_upd_nxt : func_out;
      pad_oe_n_r <= mode ? ~dir_upd_nxt : ~pad_tristate_sig;
    end
  end

  assign pad_out  = pad_out_r;
  assign pad_oe_n = pad_oe_n_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_pad_on_fall;
    @(posedge sys_clk) disable iff (rst)
    (mode && $past(mode) && $past(mode, 2) && !$past(treset) &&
     (pad_out != $past(pad_out)))
      |-> $past(tck_fall && update);
  endproperty
  a_pad_on_fall: assert property (p_pad_on_fall)
    else $error("pad changed in test mode without an update fall");

  property p_capture_input;
    @(posedge sys_clk) disable iff (rst)
    (tck_rise && capture && !output_direction_flag)
      |=> (data_sh_r == $past(pad_in));
  endproperty
  a_capture_input: assert property (p_capture_input)
    else $error("data cell did not capture the pad input");

endmodule

// file: scan_consts.svh
`ifndef SCAN_CONSTS_SVH
`define SCAN_CONSTS_SVH

// ****************************************
// Instruction codes
// ****************************************
`define IR_W            3
`define IR_EXTEST       3'h0
`define IR_RING_ONE     3'h1
`define IR_CFG_WRITE    3'h2
`define IR_RESERVED     3'h3
`define IR_SAMPLE       3'h4
`define IR_RING_TWO     3'h5
`define IR_CFG_READ     3'h6
`define IR_BYPASS       3'h7
`define IR_CAPTURE      3'h1

// ****************************************
// Boundary register geometry
// ****************************************
`define CELLS_PER_GROUP 4
`define GROUP_COUNT     2
`define PAD_COUNT       (`CELLS_PER_GROUP * `GROUP_COUNT)

// ****************************************
// Pin synchroniser layout and reset values
// ****************************************
`define SYNC_PINS       5
`define PIN_TCK         0
`define PIN_TMS         1
`define PIN_TDI         2
`define PIN_PUR         3
`define PIN_PRG         4
// TCK rests high, so its stages reset to that level and see no false rise
`define PIN_RESET_VAL   5'h01
`define TCK_IDLE        1'b1
`define TAP_CTL_RESET   10'h200
`define BYPASS_CAPTURE  1'b0

`endif

// file: scan_host.sv
`timescale 1ns/10ps

// ****************************************
// Test host driving the four test pins
// ****************************************
module scan_host
(
  // Clock
  input  wire logic sys_clk,
  // Test pins
  input  wire logic tdo,
  input  wire logic tdo_oe_n,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  // Only four pins, no test reset line
  initial
  begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // 200 ns period keeps the clock well under its ceiling
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge sys_clk);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (4) @(negedge sys_clk);
    tck = 1'b1;
    repeat (3) @(negedge sys_clk);
    // A released TDO floats to its pull-up level
    o = tdo_oe_n ? 1'b1 : tdo;
  endtask
endmodule

// file: scan_pkg.sv
`include "scan_consts.svh"

package scan_pkg;

  typedef enum logic [15:0] {
    ST_RESET    = 16'h0001,
    ST_IDLE     = 16'h0002,
    ST_SEL_DR   = 16'h0004,
    ST_CAP_DR   = 16'h0008,
    ST_SH_DR    = 16'h0010,
    ST_EX1_DR   = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EX2_DR   = 16'h0080,
    ST_UPD_DR   = 16'h0100,
    ST_SEL_IR   = 16'h0200,
    ST_CAP_IR   = 16'h0400,
    ST_SH_IR    = 16'h0800,
    ST_EX1_IR   = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EX2_IR   = 16'h4000,
    ST_UPD_IR   = 16'h8000
  } tap_state_e;

  typedef enum logic [`IR_W-1:0] {
    IN_EXTEST    = `IR_EXTEST,
    IN_RING_ONE  = `IR_RING_ONE,
    IN_CFG_WRITE = `IR_CFG_WRITE,
    IN_RESERVED  = `IR_RESERVED,
    IN_SAMPLE    = `IR_SAMPLE,
    IN_RING_TWO  = `IR_RING_TWO,
    IN_CFG_READ  = `IR_CFG_READ,
    IN_BYPASS    = `IR_BYPASS
  } instr_e;

  typedef struct packed {
    logic treset;
    logic select;
    logic enable;
    logic capture_dr;
    logic capture_ir;
    logic shift_dr;
    logic shift_ir;
    logic update_dr;
    logic update_ir;
    logic mode;
  } tap_ctl_s;

  typedef struct packed {
    logic ring_one_sel;
    logic ring_two_sel;
    logic capture;
    logic shift;
    logic update;
    logic scan_bit;
  } ring_ctl_s;

  typedef struct packed {
    logic wr_active;
    logic wr_strobe;
    logic wr_bit;
    logic rd_active;
    logic rd_strobe;
  } cfg_ctl_s;

endpackage

// file: test_boundary_scan_test_port.sv
`timescale 1ns/10ps
`include "scan_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module test_boundary_scan_test_port
  import scan_pkg::*;
  ;
  logic                  sys_clk, rst, tck, tms, tdi, tdo, tdo_oe_n, q;
  logic                  powerup_reset_in, reprogram_in, cfg_done;
  logic                  ring_one_tdo, ring_two_tdo, cfg_rd_bit;
  logic [`PAD_COUNT-1:0] pad_in, func_out, pad_tristate_sig;
  logic [`PAD_COUNT-1:0] pad_out, pad_oe_n, dir, dat;
  logic [15:0]           v, w, e;
  tap_ctl_s              tap_ctl;
  ring_ctl_s             ring_ctl;
  cfg_ctl_s              cfg_ctl;
  int                    fails, n_tests, seed, n_str, s0;

  test_port dut (.sys_clk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe_n,
    .powerup_reset_in, .reprogram_in, .tap_ctl, .pad_in, .func_out,
    .pad_tristate_sig, .pad_out, .pad_oe_n, .ring_ctl, .ring_one_tdo,
    .ring_two_tdo, .cfg_ctl, .cfg_done, .cfg_rd_bit);
  scan_host host (.sys_clk, .tdo, .tdo_oe_n, .tck, .tms, .tdi);

  always #12.5 sys_clk = ~sys_clk;

  // Strobes are one-cycle pulses, so each is seen once at the falling edge
  always @(negedge sys_clk)
    n_str <= n_str + cfg_ctl.wr_strobe + cfg_ctl.rd_strobe + ring_ctl.shift;

  // ****************************************
  // Reference model of the scan chain
  // ****************************************
  // Chain order puts pad7 data out first, then pad7 direction
  function automatic logic [15:0] chain(input logic [7:0] f);
    logic [15:0] r;
    for (int p = 0; p < 8; p++)
      {r[2*(7-p)+1], r[2*(7-p)]} = {f[p], f[p] ? func_out[p] : pad_in[p]};
    return r;
  endfunction

  task automatic split();
    for (int p = 0; p < 8; p++)
      {dir[p], dat[p]} = w[2*(7-p)+:2];
  endtask

  task automatic go(input logic m, input logic d);
    host.step(m, d, q);
  endtask

  // Walks from idle through one register scan and back to idle
  task automatic scan(input bit irp, input int n, input logic [15:0] din);
    go(1'b1, 1'b0);
    if (irp)
      go(1'b1, 1'b0);
    go(1'b0, 1'b0);
    go(1'b0, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      go(i == n - 1, din[i]);
      v[i] = q;
      if (i == 0)
      begin
        `CHK("oe_shift", 1'b0, tdo_oe_n)
        `CHK("select", irp, tap_ctl.select)
      end
    end
    go(1'b1, 1'b0);
    go(1'b0, 1'b0);
    `CHK("oe_idle", 1'b1, tdo_oe_n)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #1000000;
    fails++;
    conclude();
  end

  initial
  begin
    {seed, fails, n_tests} = {32'h0A1C, 64'h0};
    {sys_clk, rst, powerup_reset_in, reprogram_in} = 4'h4;
    {cfg_done, ring_one_tdo, cfg_rd_bit, ring_two_tdo} = 4'hE;
    {pad_in, func_out, pad_tristate_sig} = 24'($random(seed));
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    go(1'b0, 1'b0);
    for (int c = 1; c < 8; c++)
    begin
      if (c == 4)
        continue;
      scan(1'b1, 3, 16'(c));
      `CHK("ir_cap", 3'h1, v[2:0])
      `CHK("ring_one", c == 1, ring_ctl.ring_one_sel)
      `CHK("ring_two", c == 5, ring_ctl.ring_two_sel)
      `CHK("cfg_wr", c == 2, cfg_ctl.wr_active)
      `CHK("cfg_rd", c == 6, cfg_ctl.rd_active)
      `CHK("mode", 1'b0, tap_ctl.mode)
      w = 16'($random(seed));
      e = c == 1 || c == 6 ? 16'hF : c == 5 ? 16'h0 : {w[2:0], 1'b0};
      s0 = n_str;
      scan(1'b0, 4, w);
      `CHK("dr_out", e[3:0], v[3:0])
      `CHK("strobes", (c == 1 || c == 2 || c == 5 || c == 6) ? 4 : 0, n_str - s0)
    end
    scan(1'b1, 3, `IR_SAMPLE);
    w = 16'($random(seed));
    scan(1'b0, 16, w);
    `CHK("sample_cap", chain(pad_tristate_sig), v)
    `CHK("func_oe", ~pad_tristate_sig, pad_oe_n)
    `CHK("func_out", func_out, pad_out)
    split();
    scan(1'b1, 3, `IR_EXTEST);
    `CHK("mode_ext", 1'b1, tap_ctl.mode)
    repeat (2)
    begin
      e = chain(dir);
      w = 16'($random(seed));
      scan(1'b0, 16, w);
      `CHK("ext_cap", e, v)
      split();
      `CHK("ext_oe", ~dir, pad_oe_n)
      `CHK("ext_out", dat & dir, pad_out & dir)
    end
    repeat (5) go(1'b1, 1'b0);
    `CHK("tms_rst", `TAP_CTL_RESET, tap_ctl)
    `CHK("pad_rst", ~pad_tristate_sig, pad_oe_n)
    go(1'b0, 1'b0);
    scan(1'b1, 3, `IR_EXTEST);
    reprogram_in = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK("prg_rst", `TAP_CTL_RESET, tap_ctl)
    reprogram_in = 1'b0;
    repeat (6) @(negedge sys_clk);
    go(1'b0, 1'b0);
    scan(1'b1, 3, `IR_EXTEST);
    `CHK("mode_ext2", 1'b1, tap_ctl.mode)
    powerup_reset_in = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK("pur_rst", `TAP_CTL_RESET, tap_ctl)
    conclude();
  end
endmodule

// file: test_port.sv
`timescale 1ns/10ps
`include "scan_consts.svh"

// Notes on behaviour
// - Three-bit instruction selects extest, rings, config write/read, sample, bypass.
// - Extest: two bits per pin; direction bit drives pad or captures input.
// - Sample captures every pad and its direction together, pads undisturbed.
// - Ring instructions route TDI to TDO through user scan paths.
// - Config write streams TDI bits to configuration memory.
// - Config readback shifts memory out TDO once configuration is done.
// - Sixteen-state controller steps on TMS sampled at rising TCK.
// - Select is high for instruction path, low for data; TDO enable given.
// - Capture, shift and update strobes for instruction and data registers.
// - Update loads instruction latch or the pad control latches.
// - Four cells per group, all cells chained into one boundary register.
// - Each cell: direction and data shift stages feeding update latches.
// - Direction flag low captures pad input, high captures logic output.
// - Test mode high drives pads from register, low passes logic data.
// - Cells see only capture, update, shift_n, treset, TCK and mode.
// - Cells support a normal mode and a test mode.
// - TMS and TDI sampled on rising TCK; TDO changes on falling TCK.
// - Extest pad data appears on the falling TCK edge.
// - Reprogram and power-up inputs reset the test logic.
// - Four test pins only; no separate test reset pin.
module test_port
  import scan_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Test port pins
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output logic                       tdo,
  output logic                       tdo_oe_n,
  // Device resets
  input  wire logic                  powerup_reset_in,
  input  wire logic                  reprogram_in,
  // Controller status
  output tap_ctl_s                   tap_ctl,
  // Pads and logic array
  input  wire logic [`PAD_COUNT-1:0] pad_in,
  input  wire logic [`PAD_COUNT-1:0] func_out,
  input  wire logic [`PAD_COUNT-1:0] pad_tristate_sig,
  output logic      [`PAD_COUNT-1:0] pad_out,
  output logic      [`PAD_COUNT-1:0] pad_oe_n,
  // Internal scan rings
  output ring_ctl_s                  ring_ctl,
  input  wire logic                  ring_one_tdo,
  input  wire logic                  ring_two_tdo,
  // Configuration memory
  output cfg_ctl_s                   cfg_ctl,
  input  wire logic                  cfg_done,
  input  wire logic                  cfg_rd_bit
);

  logic [`SYNC_PINS-1:0] pins_raw;
  logic [`SYNC_PINS-1:0] pin_s1_r;
  logic [`SYNC_PINS-1:0] pin_s2_r;
  logic [`SYNC_PINS-1:0] pin_s3_r;
  logic [`SYNC_PINS-1:0] pin_q_r;
  logic                  tck_d_r;
  logic                  tck_rise;
  logic                  tck_fall;
  logic                  tms_q;
  logic                  tdi_q;
  logic                  test_reset;
  tap_state_e            state_r;
  tap_state_e            state_nxt;
  logic [`IR_W-1:0]      ir_sh_r;
  instr_e                ir_r;
  logic                  bypass_r;
  logic                  bsel;
  logic                  shifting;
  logic                  dr_tail;
  logic                  tdo_r;
  logic                  tdo_oe_n_r;
  tap_ctl_s              tap_ctl_r;
  ring_ctl_s             ring_ctl_r;
  cfg_ctl_s              cfg_ctl_r;
  logic [`PAD_COUNT:0]   chain;

  // ****************************************
  // Controller functions
  // ****************************************
  function automatic tap_state_e tap_next(input tap_state_e s,
                                          input logic m);
    tap_state_e n;
    n = ST_RESET;
    unique case (s)
      ST_RESET:    n = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:     n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   n = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   n = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:    n = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR:   n = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: n = m ? ST_EX2_DR : ST_PAUSE_DR;
      ST_EX2_DR:   n = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR:   n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:   n = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR:   n = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:    n = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR:   n = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: n = m ? ST_EX2_IR : ST_PAUSE_IR;
      ST_EX2_IR:   n = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR:   n = m ? ST_SEL_DR : ST_IDLE;
      default:     n = ST_RESET;
    endcase
    return n;
  endfunction

  function automatic tap_ctl_s tap_decode(input tap_state_e s,
                                          input instr_e i);
    tap_ctl_s c;
    c            = '0;
    c.treset     = (s == ST_RESET);
    c.select     = (s inside {ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
                              ST_PAUSE_IR, ST_EX2_IR, ST_UPD_IR});
    c.enable     = (s == ST_SH_IR) || (s == ST_SH_DR);
    c.capture_dr = (s == ST_CAP_DR);
    c.capture_ir = (s == ST_CAP_IR);
    c.shift_dr   = (s == ST_SH_DR);
    c.shift_ir   = (s == ST_SH_IR);
    c.update_dr  = (s == ST_UPD_DR);
    c.update_ir  = (s == ST_UPD_IR);
    c.mode       = (i == IN_EXTEST);
    return c;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  assign pins_raw = {reprogram_in, powerup_reset_in, tdi, tms, tck};

  // A pin level is accepted only once the second and third stages agree
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_r <= `PIN_RESET_VAL;
      pin_s2_r <= `PIN_RESET_VAL;
      pin_s3_r <= `PIN_RESET_VAL;
      pin_q_r  <= `PIN_RESET_VAL;
    end
    else
    begin
      pin_s1_r <= pins_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_q_r  <= (pin_s3_r & ~(pin_s2_r ^ pin_s3_r))
                | (pin_q_r & (pin_s2_r ^ pin_s3_r));
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tck_d_r <= `TCK_IDLE;
    else
      tck_d_r <= pin_q_r[`PIN_TCK];
  end

  // TMS and TDI pass the same pipeline as TCK, so they stay aligned
  assign tck_rise   = pin_q_r[`PIN_TCK] & ~tck_d_r;
  assign tck_fall   = ~pin_q_r[`PIN_TCK] & tck_d_r;
  assign tms_q      = pin_q_r[`PIN_TMS];
  assign tdi_q      = pin_q_r[`PIN_TDI];
  assign test_reset = pin_q_r[`PIN_PUR] | pin_q_r[`PIN_PRG];

  // ****************************************
  // Controller state
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    if (test_reset)
      state_nxt = ST_RESET;
    else if (tck_rise)
      state_nxt = tap_next(state_r, tms_q);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state_r <= ST_RESET;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tap_ctl_r <= `TAP_CTL_RESET;
    else
      tap_ctl_r <= tap_decode(state_r, ir_r);
  end

  assign tap_ctl = tap_ctl_r;

  // ****************************************
  // Instruction register
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ir_sh_r <= `IR_CAPTURE;
    else if (tck_rise && state_r == ST_CAP_IR)
      ir_sh_r <= `IR_CAPTURE;
    else if (tck_rise && state_r == ST_SH_IR)
      ir_sh_r <= {tdi_q, ir_sh_r[`IR_W-1:1]};
  end

  // Reset to bypass keeps the pads functional after any test reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ir_r <= IN_BYPASS;
    else if (state_r == ST_RESET)
      ir_r <= IN_BYPASS;
    else if (tck_fall && state_r == ST_UPD_IR)
      ir_r <= instr_e'(ir_sh_r);
  end

  // ****************************************
  // Data path selection
  // ****************************************
  assign bsel     = (ir_r == IN_EXTEST) || (ir_r == IN_SAMPLE);
  assign shifting = (state_r == ST_SH_IR) || (state_r == ST_SH_DR);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      bypass_r <= `BYPASS_CAPTURE;
    else if (tck_rise && state_r == ST_CAP_DR)
      bypass_r <= `BYPASS_CAPTURE;
    else if (tck_rise && state_r == ST_SH_DR)
      bypass_r <= tdi_q;
  end

  // Readback before configuration ends falls back to the single bit
  always_comb
  begin
    dr_tail = bypass_r;
    unique case (ir_r)
      IN_EXTEST, IN_SAMPLE: dr_tail = chain[`PAD_COUNT];
      IN_RING_ONE:          dr_tail = ring_one_tdo;
      IN_RING_TWO:          dr_tail = ring_two_tdo;
      IN_CFG_READ:          dr_tail = cfg_done ? cfg_rd_bit : bypass_r;
      IN_CFG_WRITE:         dr_tail = bypass_r;
      IN_RESERVED, IN_BYPASS: dr_tail = bypass_r;
    endcase
  end

  // ****************************************
  // Boundary register
  // ****************************************
  assign chain[0] = tdi_q;

  genvar g;
  for (g = 0; g < `PAD_COUNT; g++)
  begin : g_pad
    boundary_cell u_cell (
      .sys_clk          (sys_clk),
      .rst              (rst),
      .tck_rise         (tck_rise),
      .tck_fall         (tck_fall),
      .capture          (bsel && state_r == ST_CAP_DR),
      .shift_n          (!(bsel && state_r == ST_SH_DR)),
      .update           (bsel && state_r == ST_UPD_DR),
      .treset           (state_r == ST_RESET),
      .mode             (ir_r == IN_EXTEST),
      .scan_in          (chain[g]),
      .scan_out         (chain[g+1]),
      .pad_in           (pad_in[g]),
      .func_out         (func_out[g]),
      .pad_tristate_sig (pad_tristate_sig[g]),
      .pad_out          (pad_out[g]),
      .pad_oe_n         (pad_oe_n[g])
    );
  end

  // ****************************************
  // Scan rings and configuration strobes
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ring_ctl_r <= '0;
    else
    begin
      ring_ctl_r.ring_one_sel <= (ir_r == IN_RING_ONE);
      ring_ctl_r.ring_two_sel <= (ir_r == IN_RING_TWO);
      ring_ctl_r.capture      <= tck_rise && state_r == ST_CAP_DR &&
                                 (ir_r inside {IN_RING_ONE, IN_RING_TWO});
      ring_ctl_r.shift        <= tck_rise && state_r == ST_SH_DR &&
                                 (ir_r inside {IN_RING_ONE, IN_RING_TWO});
      ring_ctl_r.update       <= tck_fall && state_r == ST_UPD_DR &&
                                 (ir_r inside {IN_RING_ONE, IN_RING_TWO});
      ring_ctl_r.scan_bit     <= tdi_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cfg_ctl_r <= '0;
    else
    begin
      cfg_ctl_r.wr_active <= (ir_r == IN_CFG_WRITE);
      cfg_ctl_r.wr_strobe <= tck_rise && state_r == ST_SH_DR &&
                             ir_r == IN_CFG_WRITE;
      cfg_ctl_r.wr_bit    <= tdi_q;
      cfg_ctl_r.rd_active <= (ir_r == IN_CFG_READ) && cfg_done;
      cfg_ctl_r.rd_strobe <= tck_rise && state_r == ST_SH_DR &&
                             ir_r == IN_CFG_READ && cfg_done;
    end
  end

  assign ring_ctl = ring_ctl_r;
  assign cfg_ctl  = cfg_ctl_r;

  // ****************************************
  // Test data output, moved on falling TCK
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tdo_r <= 1'b0;
    else if (tck_fall && state_r == ST_SH_IR)
      tdo_r <= ir_sh_r[0];
    else if (tck_fall && state_r == ST_SH_DR)
      tdo_r <= dr_tail;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tdo_oe_n_r <= 1'b1;
    else if (tck_fall)
      tdo_oe_n_r <= !shifting;
  end

  assign tdo      = tdo_r;
  assign tdo_oe_n = tdo_oe_n_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_reset_stays;
    (state_r == ST_RESET && tck_rise && tms_q) |=> (state_r == ST_RESET);
  endproperty
  a_reset_stays: assert property (p_reset_stays)
    else $error("controller left reset with TMS high");

  property p_enter_capture;
    (state_r == ST_SEL_DR && tck_rise && !tms_q && !test_reset)
      |=> (state_r == ST_CAP_DR) ##1 tap_ctl_r.capture_dr;
  endproperty
  a_enter_capture: assert property (p_enter_capture)
    else $error("select-DR with TMS low did not reach capture-DR");

  property p_select_ir;
    (state_r == ST_SH_IR) |=> (tap_ctl_r.select && tap_ctl_r.shift_ir);
  endproperty
  a_select_ir: assert property (p_select_ir)
    else $error("select or shift-IR low while shifting instruction");

  property p_capture_ir;
    (tck_rise && state_r == ST_CAP_IR && !test_reset)
      |=> (ir_sh_r == `IR_CAPTURE);
  endproperty
  a_capture_ir: assert property (p_capture_ir)
    else $error("instruction capture pattern not loaded");

  property p_ir_update;
    (tck_fall && state_r == ST_UPD_IR && !test_reset)
      |=> (ir_r == $past(ir_sh_r));
  endproperty
  a_ir_update: assert property (p_ir_update)
    else $error("instruction latch missed update");

  property p_tdo_edge;
    (tdo_r != $past(tdo_r)) |-> $past(tck_fall);
  endproperty
  a_tdo_edge: assert property (p_tdo_edge)
    else $error("TDO changed away from a falling TCK");

  property p_tdo_enable;
    tck_fall |=> (tdo_oe_n_r == !$past(shifting));
  endproperty
  a_tdo_enable: assert property (p_tdo_enable)
    else $error("TDO enable disagrees with shift state");

  property p_bypass_zero;
    (tck_rise && state_r == ST_CAP_DR) |=> !bypass_r;
  endproperty
  a_bypass_zero: assert property (p_bypass_zero)
    else $error("bypass bit did not capture zero");

  property p_prog_reset;
    pin_q_r[`PIN_PRG] |=> (state_r == ST_RESET);
  endproperty
  a_prog_reset: assert property (p_prog_reset)
    else $error("reprogram did not reset the controller");

  property p_reset_mode;
    (state_r == ST_RESET) |=> (ir_r == IN_BYPASS) ##1 !tap_ctl_r.mode;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("test reset left test mode active");

  property p_extest_mode;
    (ir_r == IN_EXTEST) |=> tap_ctl_r.mode;
  endproperty
  a_extest_mode: assert property (p_extest_mode)
    else $error("extest did not raise test mode");

  c_ir_load:   cover property (tck_fall && state_r == ST_UPD_IR);
  c_extest:    cover property (ir_r == IN_EXTEST && tck_fall &&
                               state_r == ST_UPD_DR);
  c_cfg_write: cover property (cfg_ctl_r.wr_strobe);
  c_readback:  cover property (cfg_ctl_r.rd_strobe);

endmodule
